// ### rtl/irq_share_pkg.sv
package irq_share_pkg;

  // Byte offsets of the software-visible registers
  localparam logic [7:0] OFF_PSC0    = 8'h00;
  localparam logic [7:0] OFF_PSC1    = 8'h04;
  localparam logic [7:0] OFF_TIME_BASE0_CONTROL    = 8'h08;
  localparam logic [7:0] OFF_TIME_BASE1_CONTROL    = 8'h0C;
  localparam logic [7:0] OFF_ENABLE  = 8'h10;
  localparam logic [7:0] OFF_FLAGS   = 8'h14;
  localparam logic [7:0] OFF_GROUP   = 8'h18;
  localparam logic [7:0] OFF_STATUS  = 8'h1C;

  // Field positions
  localparam int CLKSEL_LSB = 0;
  localparam int TB_ON_BIT  = 7;
  localparam int TB_PER_LSB = 0;
  localparam int STACK_FULL_BIT = 0;
  localparam int GIE_BIT        = 1;

  // Source indices in enable and flag registers
  localparam int SRC_CMP  = 0;
  localparam int SRC_TB0  = 1;
  localparam int SRC_TB1  = 2;
  localparam int SRC_LVD  = 3;
  localparam int SRC_EEP  = 4;
  localparam int SRC_SIM  = 5;
  localparam int SRC_UR0  = 6;
  localparam int SRC_UR1  = 7;
  localparam int NSRC     = 8;

  // Shared groups
  localparam int NGRP     = 4;
  localparam int GRP_CMP  = 0;
  localparam int GRP_TB   = 1;
  localparam int GRP_MEM  = 2;
  localparam int GRP_COM  = 3;

  // Reset values
  localparam logic [7:0] RST_REG8  = 8'h00;
  localparam logic       RST_GIE   = 1'b0;

  // Divider and period constants
  localparam int          SYS_DIV     = 4;
  localparam logic [1:0]  DIV_LAST    = 2'h3;
  localparam int          TB_BASE_EXP = 8;
  localparam int          TB_CNT_W    = 16;
  localparam logic [1:0]  SEL_SYS     = 2'h0;
  localparam logic [1:0]  SEL_DIV4    = 2'h1;

  // Per-source bundle from the peripherals
  typedef struct packed {
    logic       cmp_out;
    logic       lvd_low;
    logic       eep_done;
    logic       sim_event;
    logic [1:0] uart_event;
  } src_in_t;

  // Core sequencer hand-off
  typedef struct packed {
    logic       req;
    logic [1:0] grp;
  } vec_req_t;

endpackage

// ### rtl/tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tick_gen
  import irq_share_pkg::*;
(
  input  wire logic       clk,        // System clock
  input  wire logic       srst,       // Sync reset
  input  wire logic       sub_tick,   // Synchronised sub clock edge pulse
  input  wire logic [1:0] clk_choice, // Prescaler source select
  input  wire logic       on,         // Generator enable
  input  wire logic [2:0] period,     // Period code
  output logic            tick        // One-cycle overflow pulse
);

  typedef struct packed {
    logic [1:0]          div;
    logic [TB_CNT_W-1:0] cnt;
    logic                tick;
  } tg_state_t;

  tg_state_t st, next_st;
  logic      pre_en;
  logic [TB_CNT_W-1:0] cnt_inc;
  logic [3:0]          sel_bit;

  // Prescaler source choice
  always_comb begin
    if (clk_choice == SEL_SYS) begin
      pre_en = 1'b1;
    end else if (clk_choice == SEL_DIV4) begin
      pre_en = (st.div == DIV_LAST);
    end else begin
      pre_en = sub_tick;
    end
  end

  assign cnt_inc = st.cnt + TB_CNT_W'(1);
  assign sel_bit = 4'(TB_BASE_EXP - 1) + {1'b0, period};

  // Free-running counter, tick on chosen bit overflow
  always_comb begin
    next_st      = st;
    next_st.div  = st.div + 2'h1;
    next_st.tick = 1'b0;
    if (!on) begin
      next_st.cnt = '0;
    end else if (pre_en) begin
      next_st.cnt  = cnt_inc;
      next_st.tick = st.cnt[sel_bit] & ~cnt_inc[sel_bit];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule
`default_nettype wire

// ### rtl/shared_irq_ctrl.sv
// Behaviour
// [RULE1] Comparator flag sets on either output edge
// [RULE2] Comparator vectors only when all enables set
// [RULE3] Full stack withholds every shared request
// [RULE4] Servicing clears global enable and group flag
// [RULE5] Software clears source flags itself
// [RULE6] Time base overflow sets its flag
// [RULE7] Time base vectors only when enabled
// [RULE8] Prescaler 0 select: sys, sys/4, sub
// [RULE9] Prescaler 1 uses the same coding
// [RULE10] Bit 7 enables time base, off at reset
// [RULE11] Time base 0 period is 2^(8+code)
// [RULE12] Time base 1 period is 2^(8+code)
// [RULE13] Unimplemented control bits read zero
// [RULE14] Low supply sets flag, needs enables
// [RULE15] EEPROM erase/write end sets flag
// [RULE16] Serial byte, address match, timeout set flag
// [RULE17] UART events pulse its request
// [RULE18] UART status clears only by UART itself
// [RULE19] Group flag sets when any member raises
// [RULE20] Time base is free counter on prescaler
`timescale 1ns/1ps
`default_nettype none
module shared_irq_ctrl
  import irq_share_pkg::*;
(
  input  wire logic        clk,          // System clock
  input  wire logic        srst,         // Sync reset, active high
  input  wire logic        hsel,         // AHB select
  input  wire logic [31:0] haddr,        // AHB address
  input  wire logic [1:0]  htrans,       // AHB transfer type
  input  wire logic        hwrite,       // AHB write
  input  wire logic [2:0]  hsize,        // AHB size
  input  wire logic [31:0] hwdata,       // AHB write data
  input  wire logic        hready,       // AHB ready in
  output logic      [31:0] hrdata,       // AHB read data
  output logic             hreadyout,    // AHB ready out
  output logic             hresp,        // AHB response
  input  wire logic        sub_clk_pin,  // Sub clock, asynchronous
  input  wire irq_share_pkg::src_in_t src, // Peripheral events
  input  wire logic        stack_full,   // Core stack full
  input  wire logic        vec_ack,      // Core took the vector
  input  wire logic        reti,         // Return sets global enable
  output irq_share_pkg::vec_req_t vreq,  // Vector request to core
  output logic             irq_pending   // Any group flag set
);

  typedef struct packed {
    logic [1:0]      psc0;
    logic [1:0]      psc1;
    logic            tb0_on;
    logic [2:0]      tb0_per;
    logic            tb1_on;
    logic [2:0]      tb1_per;
    logic [NSRC-1:0] en;
    logic [NSRC-1:0] flag;
    logic [NGRP-1:0] gen;
    logic [NGRP-1:0] gflag;
    logic            gie;
    logic            cmp_q;
    logic [2:0]      sub_sync;
    logic            dp_wr;
    logic [7:0]      dp_addr;
    logic [31:0]     rdata;
  } st_t;

  st_t st, next_st;
  logic            tb0_tick;
  logic            tb1_tick;
  logic            sub_tick;
  logic [NSRC-1:0] raise;
  logic [NGRP-1:0] grp_raise;
  logic [NGRP-1:0] grp_ready;
  logic [1:0]      win_grp;
  logic            win_any;
  logic            addr_ok;
  logic [31:0]     rd_mux;
  logic            stack_full_q;

  // Source-to-group map
  function automatic logic [1:0] grp_of(input int s);
    case (s)
      SRC_CMP:          grp_of = 2'(GRP_CMP);
      SRC_TB0, SRC_TB1: grp_of = 2'(GRP_TB);
      SRC_LVD, SRC_EEP: grp_of = 2'(GRP_MEM);
      default:          grp_of = 2'(GRP_COM);
    endcase
  endfunction

  // Sub clock edge pulse after two-flop sync
  assign sub_tick = st.sub_sync[1] & ~st.sub_sync[2];

  // Time base generators
  tick_gen u_tb0 (
    .clk        (clk),
    .srst       (srst),
    .sub_tick   (sub_tick),
    .clk_choice (st.psc0),        // RULE8
    .on         (st.tb0_on),      // RULE10
    .period     (st.tb0_per),     // RULE11
    .tick       (tb0_tick)
  );

  tick_gen u_tb1 (
    .clk        (clk),
    .srst       (srst),
    .sub_tick   (sub_tick),
    .clk_choice (st.psc1),        // RULE9
    .on         (st.tb1_on),      // RULE10
    .period     (st.tb1_per),     // RULE12
    .tick       (tb1_tick)
  );

  // Source events
  always_comb begin
    raise          = '0;
    raise[SRC_CMP] = src.cmp_out ^ st.cmp_q;       // RULE1
    raise[SRC_TB0] = tb0_tick;                     // RULE6 RULE20
    raise[SRC_TB1] = tb1_tick;                     // RULE6 RULE20
    raise[SRC_LVD] = src.lvd_low;                  // RULE14
    raise[SRC_EEP] = src.eep_done;                 // RULE15
    raise[SRC_SIM] = src.sim_event;                // RULE16
    raise[SRC_UR0] = src.uart_event[0];            // RULE17
    raise[SRC_UR1] = src.uart_event[1];            // RULE17
  end

  // Group raise and readiness per group
  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : g_grp
      always_comb begin
        grp_raise[g] = 1'b0;
        grp_ready[g] = 1'b0;
        for (int s = 0; s < NSRC; s++) begin
          if (grp_of(s) == 2'(g)) begin
            grp_raise[g] = grp_raise[g] | raise[s];             // RULE19
            grp_ready[g] = grp_ready[g] | (st.flag[s] & st.en[s]); // RULE2 RULE7
          end
        end
        grp_ready[g] = grp_ready[g] & st.gen[g] & st.gflag[g];
      end
    end
  endgenerate

  // Fixed priority, lowest group first
  always_comb begin
    win_any = 1'b0;
    win_grp = '0;
    for (int i = NGRP - 1; i >= 0; i--) begin
      if (grp_ready[i]) begin
        win_any = 1'b1;
        win_grp = 2'(i);
      end
    end
  end

  assign vreq.req    = win_any & st.gie & ~stack_full; // RULE3
  assign vreq.grp    = win_grp;
  assign irq_pending = |st.gflag;
  assign stack_full_q = stack_full;

  // Address decode
  assign addr_ok = (st.dp_addr[7:5] == 3'h0) && (st.dp_addr[1:0] == 2'h0);

  // Read mux, unimplemented bits zero
  always_comb begin
    rd_mux = '0;
    case (haddr[7:0])
      OFF_PSC0:   rd_mux[1:0] = st.psc0;                        // RULE13
      OFF_PSC1:   rd_mux[1:0] = st.psc1;                        // RULE13
      OFF_TIME_BASE0_CONTROL:   rd_mux[7:0] = {st.tb0_on, 4'h0, st.tb0_per};  // RULE13
      OFF_TIME_BASE1_CONTROL:   rd_mux[7:0] = {st.tb1_on, 4'h0, st.tb1_per};  // RULE13
      OFF_ENABLE: rd_mux[NSRC-1:0] = st.en;
      OFF_FLAGS:  rd_mux[NSRC-1:0] = st.flag;
      OFF_GROUP:  rd_mux[7:0] = {st.gflag, st.gen};
      OFF_STATUS: rd_mux[1:0] = {st.gie, stack_full_q};
      default:    rd_mux = '0;
    endcase
  end

  // Next state: bus, flags, servicing
  always_comb begin
    next_st          = st;
    next_st.cmp_q    = src.cmp_out;
    next_st.sub_sync = {st.sub_sync[1:0], sub_clk_pin};
    next_st.dp_wr    = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_st.dp_wr   = hwrite;
      next_st.dp_addr = haddr[7:0];
      next_st.rdata   = hwrite ? 32'h0000_0000 : rd_mux;
    end
    // Register writes
    if (st.dp_wr && addr_ok) begin
      case (st.dp_addr)
        OFF_PSC0: next_st.psc0 = hwdata[CLKSEL_LSB +: 2];      // RULE8
        OFF_PSC1: next_st.psc1 = hwdata[CLKSEL_LSB +: 2];      // RULE9
        OFF_TIME_BASE0_CONTROL: begin
          next_st.tb0_on  = hwdata[TB_ON_BIT];                 // RULE10
          next_st.tb0_per = hwdata[TB_PER_LSB +: 3];
        end
        OFF_TIME_BASE1_CONTROL: begin
          next_st.tb1_on  = hwdata[TB_ON_BIT];                 // RULE10
          next_st.tb1_per = hwdata[TB_PER_LSB +: 3];
        end
        OFF_ENABLE: next_st.en = hwdata[NSRC-1:0];
        OFF_FLAGS:  next_st.flag = hwdata[NSRC-1:0];           // RULE5
        OFF_GROUP: begin
          next_st.gen   = hwdata[NGRP-1:0];
          next_st.gflag = hwdata[2*NGRP-1:NGRP];
        end
        OFF_STATUS: next_st.gie = hwdata[GIE_BIT];
        default: ;
      endcase
    end
    if (reti) begin
      next_st.gie = 1'b1;
    end
    // Servicing: source flags stay set
    if (vreq.req && vec_ack) begin
      next_st.gie = 1'b0;                                      // RULE4
      next_st.gflag[win_grp] = 1'b0;                           // RULE4 RULE18
    end
    // Hardware set wins over any clear
    next_st.flag  = next_st.flag | raise;                      // RULE1 RULE6
    next_st.gflag = next_st.gflag | grp_raise;                 // RULE19
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st      <= '0;
      st.gie  <= RST_GIE;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata    = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Assertions
  property p_cmp_edge;
    @(posedge clk) disable iff (srst)
      (src.cmp_out != $past(src.cmp_out)) |=> st.flag[SRC_CMP];
  endproperty
  a_cmp_edge: assert property (p_cmp_edge) else $error("cmp edge lost"); // RULE1

  property p_stack_block;
    @(posedge clk) disable iff (srst) stack_full |-> !vreq.req;
  endproperty
  a_stack_block: assert property (p_stack_block) else $error("req with full stack"); // RULE3

  property p_req_needs;
    @(posedge clk) disable iff (srst)
      vreq.req |-> st.gie && st.gen[vreq.grp] && st.gflag[vreq.grp];
  endproperty
  a_req_needs: assert property (p_req_needs) else $error("req without enables"); // RULE2

  property p_service;
    @(posedge clk) disable iff (srst)
      (vreq.req && vec_ack && !reti && !grp_raise[vreq.grp])
        |=> !st.gie && !st.gflag[$past(vreq.grp)];
  endproperty
  a_service: assert property (p_service) else $error("service clear missing"); // RULE4

  property p_src_keep;
    @(posedge clk) disable iff (srst)
      (vreq.req && vec_ack && !st.dp_wr) |=> st.flag == $past(st.flag | raise);
  endproperty
  a_src_keep: assert property (p_src_keep) else $error("source flag touched"); // RULE4

  property p_tb_flag;
    @(posedge clk) disable iff (srst) tb0_tick |=> st.flag[SRC_TB0];
  endproperty
  a_tb_flag: assert property (p_tb_flag) else $error("tb0 tick lost"); // RULE6

  property p_tb_off;
    @(posedge clk) disable iff (srst) !st.tb0_on |=> !tb0_tick;
  endproperty
  a_tb_off: assert property (p_tb_off) else $error("tb0 ticks while off"); // RULE10

  property p_grp_set;
    @(posedge clk) disable iff (srst) raise[SRC_SIM] |=> st.gflag[GRP_COM];
  endproperty
  a_grp_set: assert property (p_grp_set) else $error("group flag missed"); // RULE19

  property p_tb_fast;
    @(posedge clk) disable iff (srst)
      (st.tb0_on && st.psc0 == SEL_SYS && st.tb0_per == 3'h0 && tb0_tick)
        ##1 (st.tb0_on && st.psc0 == SEL_SYS && st.tb0_per == 3'h0) [*8]
        |-> !tb0_tick;
  endproperty
  a_tb_fast: assert property (p_tb_fast) else $error("tb0 period too short"); // RULE11

  // Low supply, EEPROM, serial and UART 1 events reach their flags and groups, tb1 stays quiet when off, unused time base 1 control bits read zero
  property p_tb1_flag;
    @(posedge clk) disable iff (srst) tb1_tick |=> st.flag[SRC_TB1];
  endproperty
  a_tb1_flag: assert property (p_tb1_flag) else $error("tb1 tick lost"); // RULE6

  property p_tb1_off;
    @(posedge clk) disable iff (srst) !st.tb1_on |=> !tb1_tick;
  endproperty
  a_tb1_off: assert property (p_tb1_off) else $error("tb1 ticks while off"); // RULE10

  property p_lvd_set;
    @(posedge clk) disable iff (srst)
      src.lvd_low |=> st.flag[SRC_LVD] && st.gflag[GRP_MEM];
  endproperty
  a_lvd_set: assert property (p_lvd_set) else $error("low supply event lost"); // RULE14

  property p_eep_set;
    @(posedge clk) disable iff (srst)
      src.eep_done |=> st.flag[SRC_EEP] && st.gflag[GRP_MEM];
  endproperty
  a_eep_set: assert property (p_eep_set) else $error("eeprom done event lost"); // RULE15

  property p_sim_set;
    @(posedge clk) disable iff (srst)
      src.sim_event |=> st.flag[SRC_SIM] && st.gflag[GRP_COM];
  endproperty
  a_sim_set: assert property (p_sim_set) else $error("serial event lost"); // RULE16

  property p_uart_set;
    @(posedge clk) disable iff (srst)
      src.uart_event[1] |=> st.flag[SRC_UR1] && st.gflag[GRP_COM];
  endproperty
  a_uart_set: assert property (p_uart_set) else $error("uart event lost"); // RULE17

  property p_ctrl_zero;
    @(posedge clk) disable iff (srst)
      (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == OFF_TIME_BASE1_CONTROL)
        |=> {hrdata[31:8], hrdata[6:3]} == 28'h000_0000;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused control bits read set"); // RULE13

  c_service: cover property (@(posedge clk) disable iff (srst) vreq.req && vec_ack);
  c_tb1:     cover property (@(posedge clk) disable iff (srst) tb1_tick);
  c_blocked: cover property (@(posedge clk) disable iff (srst) win_any && st.gie && stack_full);
  c_mem_grp: cover property (@(posedge clk) disable iff (srst) vreq.req && vreq.grp == 2'(GRP_MEM));
  c_com_grp: cover property (@(posedge clk) disable iff (srst) vreq.req && vreq.grp == 2'(GRP_COM));

endmodule
`default_nettype wire

// ### dv/core_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_seq_model
  import irq_share_pkg::*;
(
  input  wire logic                    clk,        // System clock
  input  wire logic                    srst,       // Sync reset
  input  wire irq_share_pkg::vec_req_t vreq,       // Vector request
  input  wire logic                    stall,      // Hold off taking
  input  wire logic                    full_in,    // Stack full command
  input  wire logic                    ret_in,     // Return command
  output var logic                     stack_full, // Stack full level
  output var logic                     vec_ack,    // Vector taken pulse
  output var logic                     reti,       // Return pulse
  output var int                       n_ack,      // Vectors taken
  output var int                       t_last,     // Cycle of last take
  output var int                       t_prev,     // Cycle of take before
  output var logic [1:0]               grp_seen    // Group of last take
);
  int cyc;
  // Quiet levels before the first edge
  initial begin
    stack_full = 1'b0;
    vec_ack = 1'b0;
    reti = 1'b0;
    grp_seen = 2'h0;
  end
  // Take a standing request once, stamp it, then drop the pulse
  always @(posedge clk) begin
    cyc <= cyc + 1;
    stack_full <= full_in;
    reti <= ret_in;
    vec_ack <= 1'b0;
    if (srst) begin
      n_ack <= 0;
    end else if (vreq.req && !stall && !vec_ack) begin
      vec_ack <= 1'b1;
      n_ack <= n_ack + 1;
      t_prev <= t_last;
      t_last <= cyc;
      grp_seen <= vreq.grp;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_shared_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_shared_irq_ctrl;
  import irq_share_pkg::*;
  logic        clk = 0, srst = 1, hsel = 0, hwrite = 0, sub_clk_pin = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
  logic [1:0]  htrans = 0, grp_seen;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, irq_pending, stack_full, vec_ack, reti;
  logic        stall = 1, full_in = 0, ret_in = 0;
  vec_req_t    vreq;
  src_in_t     src = '0;
  int          n_errors = 0, n_compared = 0, n_ack, t_last, t_prev, cyc = 0, k;
  int          fb[5] = '{3, 4, 5, 6, 7};
  int          sb[5] = '{4, 3, 2, 0, 1};
  int          gb[5] = '{2, 2, 3, 3, 3};

  shared_irq_ctrl shared_irq_ctrl_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sub_clk_pin(sub_clk_pin), .src(src), .stack_full(stack_full), .vec_ack(vec_ack),
    .reti(reti), .vreq(vreq), .irq_pending(irq_pending));
  core_seq_model core_seq_model_inst (.clk(clk), .srst(srst), .vreq(vreq), .stall(stall), .full_in(full_in),
    .ret_in(ret_in), .stack_full(stack_full), .vec_ack(vec_ack), .reti(reti), .n_ack(n_ack), .t_last(t_last),
    .t_prev(t_prev), .grp_seen(grp_seen));

  always #5 clk = ~clk;
  // Sub clock at a quarter rate, and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sub_clk_pin <= cyc[1];
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One AHB single word transfer, address phase then data phase
  task xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rv = hrdata;
    chk("response", 32'h0, hresp);
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(logic [7:0] a, logic [31:0] exp, string what);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rv);
  endtask
  task pulse_ret();
    ret_in <= 1'b1;
    @(posedge clk);
    ret_in <= 1'b0;
  endtask
  // Time two successive vectors of one time base
  task period(logic [7:0] pa, logic [1:0] sel, logic [7:0] ca, logic [2:0] code, int bitn, int exp);
    wr(pa, {30'h0, sel});
    wr(OFF_ENABLE, 32'h1 << bitn);
    wr(OFF_GROUP, 32'h2);
    wr(ca, {24'h0, 8'h80 | code});
    wr(OFF_STATUS, 32'h2);
    k = n_ack;
    stall <= 1'b0;
    while (n_ack == k) @(posedge clk);
    wr(OFF_FLAGS, 32'h0);
    pulse_ret();
    k = n_ack;
    while (n_ack == k) @(posedge clk);
    chk("tick interval", exp, t_last - t_prev);
    chk("tick group", GRP_TB, grp_seen);
    stall <= 1'b1;
    wr(ca, 32'h0);
    wr(OFF_FLAGS, 32'h0);
    $display("test period %0d done", exp);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0, "reset value");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(8'(i * 4), 32'hFFFF_FFFF);
      rd(8'(i * 4), (i < 2) ? 32'h3 : 32'h87, "field mask");
      wr(8'(i * 4), 32'h0);
    end
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, "unmapped");
    wr(OFF_FLAGS, 32'h0);
    $display("test masks done");
    wr(OFF_ENABLE, 32'h1);
    wr(OFF_GROUP, 32'h1);
    full_in <= 1'b1;
    src.cmp_out <= 1'b1;
    repeat (4) @(posedge clk);
    rd(OFF_FLAGS, 32'h1, "cmp flag rise");
    xfer(1'b0, OFF_GROUP, 32'h0);
    chk("cmp group flag", 32'h1, rv[4 + GRP_CMP]);
    chk("pending", 32'h1, irq_pending);
    wr(OFF_STATUS, 32'h2);
    stall <= 1'b0;
    repeat (3) @(posedge clk);
    chk("req on full stack", 32'h0, vreq.req);
    k = n_ack;
    full_in <= 1'b0;
    repeat (6) @(posedge clk);
    chk("cmp vectors", k + 1, n_ack);
    chk("cmp group", GRP_CMP, grp_seen);
    rd(OFF_STATUS, 32'h0, "gie after service");
    xfer(1'b0, OFF_GROUP, 32'h0);
    chk("group flag after service", 32'h0, rv[4 + GRP_CMP]);
    chk("pending after service", 32'h0, irq_pending);
    rd(OFF_FLAGS, 32'h1, "cmp flag kept");
    stall <= 1'b1;
    wr(OFF_FLAGS, 32'h0);
    rd(OFF_FLAGS, 32'h0, "cmp flag cleared");
    src.cmp_out <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFF_FLAGS, 32'h1, "cmp flag fall");
    pulse_ret();
    repeat (2) @(posedge clk);
    rd(OFF_STATUS, 32'h2, "gie after return");
    wr(OFF_STATUS, 32'h0);
    wr(OFF_ENABLE, 32'h0);
    wr(OFF_GROUP, 32'h0);
    $display("test comparator done");
    for (int i = 0; i < 5; i++) begin
      wr(OFF_FLAGS, 32'h0);
      src <= src_in_t'(6'h1 << sb[i]);
      @(posedge clk);
      src <= '0;
      repeat (3) @(posedge clk);
      rd(OFF_FLAGS, 32'h1 << fb[i], "source flag");
      xfer(1'b0, OFF_GROUP, 32'h0);
      chk("source group flag", 32'h1, rv[4 + gb[i]]);
    end
    wr(OFF_FLAGS, 32'h0);
    $display("test sources done");
    wr(OFF_ENABLE, 32'h28);
    wr(OFF_GROUP, 32'hC);
    src <= src_in_t'(6'h14);
    @(posedge clk);
    src <= '0;
    wr(OFF_STATUS, 32'h2);
    k = n_ack;
    stall <= 1'b0;
    while (n_ack == k) @(posedge clk);
    chk("first group", GRP_MEM, grp_seen);
    pulse_ret();
    k = n_ack;
    while (n_ack == k) @(posedge clk);
    chk("second group", GRP_COM, grp_seen);
    stall <= 1'b1;
    wr(OFF_ENABLE, 32'h0);
    wr(OFF_GROUP, 32'h0);
    wr(OFF_FLAGS, 32'h0);
    $display("test groups done");
    period(OFF_PSC0, 2'h0, OFF_TIME_BASE0_CONTROL, 3'h0, SRC_TB0, 256);
    k = n_ack;
    wr(OFF_STATUS, 32'h2);
    stall <= 1'b0;
    repeat (600) @(posedge clk);
    chk("vectors while off", k, n_ack);
    stall <= 1'b1;
    wr(OFF_STATUS, 32'h0);
    period(OFF_PSC0, 2'h1, OFF_TIME_BASE0_CONTROL, 3'h1, SRC_TB0, 2048);
    period(OFF_PSC0, 2'h3, OFF_TIME_BASE0_CONTROL, 3'h0, SRC_TB0, 1024);
    period(OFF_PSC1, 2'h1, OFF_TIME_BASE1_CONTROL, 3'h0, SRC_TB1, 1024);
    period(OFF_PSC1, 2'h2, OFF_TIME_BASE1_CONTROL, 3'h0, SRC_TB1, 1024);
    period(OFF_PSC1, 2'h0, OFF_TIME_BASE1_CONTROL, 3'h2, SRC_TB1, 1024);
    complete_run();
  end
endmodule
`default_nettype wire
